//--- verilog/almon_top.sv
// Alarm outputs, acknowledge and voltage/frequency window monitor
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// =========================================
// Window comparator with hysteresis
module almon_win
    import almon_pkg::*;
#(
    parameter int LIM_W = 8,
    parameter int HYST = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Scaled value and one limit step (1 % voltage, 0.01 % frequency)
    input wire logic [CMP_W-1:0] lhs,
    input wire logic [CMP_W-1:0] unit,
    // Limits
    input wire logic [LIM_W-1:0] hiLim,
    input wire logic [LIM_W-1:0] loLim,
    // Result
    output var logic inRange
);
    logic highQ;
    logic lowQ;
    logic [CMP_W-1:0] hiT;
    logic [CMP_W-1:0] hiBack;
    logic [CMP_W-1:0] loT;
    logic [CMP_W-1:0] loBack;
    logic highD;
    logic lowD;

    // Trip and return thresholds
    assign hiT = CMP_W'(unit * CMP_W'(hiLim));
    assign hiBack = CMP_W'(unit * CMP_W'(hiLim - LIM_W'(HYST)));
    assign loT = CMP_W'(unit * CMP_W'(loLim));
    assign loBack = CMP_W'(unit * CMP_W'(loLim + LIM_W'(HYST)));
    assign highD = highQ ? (lhs > hiBack) : (lhs > hiT);
    assign lowD = lowQ ? (lhs < loBack) : (lhs < loT);

    // State of both edges
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            highQ <= 1'b0;
            lowQ <= 1'b0;
            inRange <= 1'b0;
        end else begin
            highQ <= highD;
            lowQ <= lowD;
            inRange <= ~highD & ~lowD;
        end
    end

    default clocking cbw @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_trip;
        (lhs > hiT) || (lhs < loT) |=> !inRange;
    endproperty
    a_trip: assert property (p_trip) else $error("no trip");

    property p_hold;
        highQ && (lhs > hiBack) |=> highQ ##0 !inRange;
    endproperty
    a_hold: assert property (p_hold) else $error("early return");
endmodule

module almon_top
    import almon_pkg::*;
#(
    parameter int NW = 8,
    parameter int NC = 8,
    parameter int PULSE_CYC = NEW_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // Alarm conditions and acknowledge sources
    input wire logic [NW-1:0] warnCond,
    input wire logic [NC-1:0] critCond,
    input wire logic alarm_ack_input,
    input wire logic resetButton,
    input wire logic group_supervisor_ack,
    // Measurements, secondary volts and 0.01 Hz
    input wire logic [MEAS_W-1:0] grpVoltLl,
    input wire logic [MEAS_W-1:0] grpVoltLn,
    input wire logic [MEAS_W-1:0] grpFreq,
    input wire logic [MEAS_W-1:0] busVoltLl,
    input wire logic [MEAS_W-1:0] busVoltLn,
    input wire logic [MEAS_W-1:0] busFreq,
    // Alarm relays
    output var logic new_alarm_output,
    output var logic warning_alarm_output,
    output var logic critical_alarm_output,
    // Monitor flags
    output var logic grpInRange,
    output var logic grpDead,
    output var logic busInRange,
    output var logic busDead,
    // Interrupt
    output var logic irq
);
    // =========================================
    // Settings and state
    logic lnMode_q;
    logic [PCT_W-1:0] vhi_q;
    logic [PCT_W-1:0] vlo_q;
    logic [FPCT_W-1:0] fhi_q;
    logic [FPCT_W-1:0] flo_q;
    logic [PCT_W-1:0] dead_q;
    logic [PRI_W-1:0] ptPri_q;
    logic [SEC_W-1:0] ptSec_q;
    logic [PRI_W-1:0] ratV_q;
    logic [MEAS_W-1:0] ratF_q;
    logic [IRQ_W-1:0] istat_q;
    logic [IRQ_W-1:0] imask_q;
    logic [NW-1:0] warnPrev_q;
    logic [NC-1:0] critPrev_q;
    logic [NW-1:0] warnPend_q;
    logic [NC-1:0] critPend_q;
    logic [31:0] cnt_q;

    function automatic logic [31:0] clampv(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // =========================================
    // APB decode
    logic setup;
    logic wr;
    logic hit;
    logic weCtrl;
    logic swAck;
    logic [IRQ_W-1:0] w1c;
    logic [31:0] rdata;
    logic [31:0] flags;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready;
    assign weCtrl = wr && (paddr == OFS_CTRL);
    assign swAck = weCtrl & pwdata[CTRL_ACK];
    assign w1c = (wr && paddr == OFS_ISTAT) ? pwdata[IRQ_W-1:0] : '0;
    assign hit = (paddr <= OFS_CPEND) && (paddr[1:0] == 2'h0);
    assign flags = {25'h0, critical_alarm_output, warning_alarm_output,
                    new_alarm_output, busDead, busInRange, grpDead,
                    grpInRange};

    // Read multiplexer
    always_comb begin
        case (paddr)
            OFS_CTRL: rdata = {31'h0, lnMode_q};
            OFS_VHI: rdata = 32'(vhi_q);
            OFS_VLO: rdata = 32'(vlo_q);
            OFS_FHI: rdata = 32'(fhi_q);
            OFS_FLO: rdata = 32'(flo_q);
            OFS_DEAD: rdata = 32'(dead_q);
            OFS_PTPRI: rdata = 32'(ptPri_q);
            OFS_PTSEC: rdata = 32'(ptSec_q);
            OFS_RATV: rdata = 32'(ratV_q);
            OFS_RATF: rdata = 32'(ratF_q);
            OFS_FLAGS: rdata = flags;
            OFS_ISTAT: rdata = 32'(istat_q);
            OFS_IMASK: rdata = 32'(imask_q);
            OFS_WPEND: rdata = 32'(warnPend_q);
            OFS_CPEND: rdata = 32'(critPend_q);
            default: rdata = 32'h0;
        endcase
    end

    // Answer one cycle after setup
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            prdata <= (setup && !pwrite) ? rdata : 32'h0;
        end
    end

    // Setting registers, window limit and PT ratio writes clamped into range
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lnMode_q <= 1'b0;
            vhi_q <= PCT_W'(VHI_RST);
            vlo_q <= PCT_W'(VLO_RST);
            fhi_q <= FPCT_W'(FHI_RST);
            flo_q <= FPCT_W'(FLO_RST);
            dead_q <= PCT_W'(DEAD_RST);
            ptPri_q <= PRI_W'(PTPRI_RST);
            ptSec_q <= SEC_W'(PTSEC_RST);
            ratV_q <= PRI_W'(RATV_RST);
            ratF_q <= MEAS_W'(RATF_RST);
            imask_q <= '0;
        end else if (wr) begin
            case (paddr)
                OFS_CTRL: lnMode_q <= pwdata[CTRL_LN];
                OFS_VHI: vhi_q <= PCT_W'(clampv(pwdata, VHI_MIN, VHI_MAX));
                OFS_VLO: vlo_q <= PCT_W'(clampv(pwdata, VLO_MIN, VLO_MAX));
                OFS_FHI: fhi_q <= FPCT_W'(clampv(pwdata, FHI_MIN, FHI_MAX));
                OFS_FLO: flo_q <= FPCT_W'(clampv(pwdata, FLO_MIN, FLO_MAX));
                OFS_DEAD: dead_q <= pwdata[PCT_W-1:0];
                OFS_PTPRI: ptPri_q <= PRI_W'(clampv(pwdata, PTPRI_MIN,
                                                    PTPRI_MAX));
                OFS_PTSEC: ptSec_q <= SEC_W'(clampv(pwdata, PTSEC_MIN,
                                                    PTSEC_MAX));
                OFS_RATV: ratV_q <= pwdata[PRI_W-1:0];
                OFS_RATF: ratF_q <= pwdata[MEAS_W-1:0];
                OFS_IMASK: imask_q <= pwdata[IRQ_W-1:0];
                default: lnMode_q <= lnMode_q;
            endcase
        end
    end

    // =========================================
    // Alarms
    logic ackAny;
    logic [NW-1:0] warnRise;
    logic [NC-1:0] critRise;
    logic [NW-1:0] warnPend_d;
    logic [NC-1:0] critPend_d;
    logic anyNew;
    logic [31:0] cnt_d;
    assign ackAny = alarm_ack_input | resetButton | group_supervisor_ack
                    | swAck;
    assign warnRise = warnCond & ~warnPrev_q;
    assign critRise = critCond & ~critPrev_q;
    assign warnPend_d = warnRise
                        | (warnPend_q & ~({NW{ackAny}} & ~warnCond));
    assign critPend_d = critRise
                        | (critPend_q & ~({NC{ackAny}} & ~critCond));
    assign anyNew = (|warnRise) | (|critRise);
    assign cnt_d = anyNew ? 32'(PULSE_CYC)
                   : ((cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0);

    // Alarm state and relays
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            warnPrev_q <= '0;
            critPrev_q <= '0;
            warnPend_q <= '0;
            critPend_q <= '0;
            cnt_q <= 32'h0;
            new_alarm_output <= 1'b0;
            warning_alarm_output <= 1'b0;
            critical_alarm_output <= 1'b0;
        end else begin
            warnPrev_q <= warnCond;
            critPrev_q <= critCond;
            warnPend_q <= warnPend_d;
            critPend_q <= critPend_d;
            cnt_q <= cnt_d;
            new_alarm_output <= cnt_d != 32'h0;
            warning_alarm_output <= |warnPend_q;
            critical_alarm_output <= |critPend_q;
        end
    end

    // =========================================
    // Scaling and windows
    logic [MEAS_W-1:0] gV;
    logic [MEAS_W-1:0] bV;
    logic [CMP_W-1:0] priX;
    logic [CMP_W-1:0] vUnit;
    logic [CMP_W-1:0] fUnit;
    logic [CMP_W-1:0] gVLhs;
    logic [CMP_W-1:0] bVLhs;
    logic [CMP_W-1:0] gFLhs;
    logic [CMP_W-1:0] bFLhs;
    logic [CMP_W-1:0] deadT;
    logic gvOk;
    logic gfOk;
    logic bvOk;
    logic bfOk;
    assign gV = lnMode_q ? grpVoltLn : grpVoltLl;
    assign bV = lnMode_q ? busVoltLn : busVoltLl;
    // primary value is measured times pri over sec
    assign priX = CMP_W'(ptPri_q);
    assign vUnit = CMP_W'(CMP_W'(ratV_q) * CMP_W'(ptSec_q));
    assign fUnit = CMP_W'(ratF_q);
    assign gVLhs = CMP_W'(CMP_W'(gV) * priX * V_SCALE);
    assign bVLhs = CMP_W'(CMP_W'(bV) * priX * V_SCALE);
    assign gFLhs = CMP_W'(CMP_W'(grpFreq) * F_SCALE);
    assign bFLhs = CMP_W'(CMP_W'(busFreq) * F_SCALE);
    assign deadT = CMP_W'(vUnit * CMP_W'(dead_q));

    almon_win #(.LIM_W(PCT_W), .HYST(V_HYST)) uGv (
        .clk(clk), .sys_rst(sys_rst), .lhs(gVLhs), .unit(vUnit),
        .hiLim(vhi_q), .loLim(vlo_q), .inRange(gvOk));
    almon_win #(.LIM_W(FPCT_W), .HYST(F_HYST)) uGf (
        .clk(clk), .sys_rst(sys_rst), .lhs(gFLhs), .unit(fUnit),
        .hiLim(fhi_q), .loLim(flo_q), .inRange(gfOk));
    almon_win #(.LIM_W(PCT_W), .HYST(V_HYST)) uBv (
        .clk(clk), .sys_rst(sys_rst), .lhs(bVLhs), .unit(vUnit),
        .hiLim(vhi_q), .loLim(vlo_q), .inRange(bvOk));
    almon_win #(.LIM_W(FPCT_W), .HYST(F_HYST)) uBf (
        .clk(clk), .sys_rst(sys_rst), .lhs(bFLhs), .unit(fUnit),
        .hiLim(fhi_q), .loLim(flo_q), .inRange(bfOk));

    // =========================================
    // Flags and interrupt
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] istat_d;
    assign ev = {busInRange ^ (bvOk & bfOk), grpInRange ^ (gvOk & gfOk),
                 ackAny, anyNew};
    // Set wins over write-one clear
    assign istat_d = (istat_q & ~w1c) | ev;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            grpInRange <= 1'b0;
            busInRange <= 1'b0;
            grpDead <= 1'b0;
            busDead <= 1'b0;
            istat_q <= '0;
            irq <= 1'b0;
        end else begin
            grpInRange <= gvOk & gfOk;
            busInRange <= bvOk & bfOk;
            grpDead <= gVLhs < deadT;
            busDead <= bVLhs < deadT;
            istat_q <= istat_d;
            irq <= |(istat_q & imask_q);
        end
    end

    // =========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_newpulse;
        anyNew |=> new_alarm_output && cnt_q == 32'(PULSE_CYC);
    endproperty
    a_newpulse: assert property (p_newpulse) else $error("pulse");

    property p_warn;
        ##1 warning_alarm_output == $past(|warnPend_q);
    endproperty
    a_warn: assert property (p_warn) else $error("warn relay");

    property p_crit;
        ##1 critical_alarm_output == $past(|critPend_q);
    endproperty
    a_crit: assert property (p_crit) else $error("crit relay");

    property p_noack;
        ##1 (warnPend_q & $past(warnPend_q & warnCond))
            == $past(warnPend_q & warnCond);
    endproperty
    a_noack: assert property (p_noack) else $error("acked early");

    property p_ackall;
        ackAny && warnCond == '0 && critCond == '0
            |=> warnPend_q == '0 && critPend_q == '0;
    endproperty
    a_ackall: assert property (p_ackall) else $error("not all");

    property p_acksrc;
        alarm_ack_input || resetButton || group_supervisor_ack
            |=> istat_q[IRQ_ACK];
    endproperty
    a_acksrc: assert property (p_acksrc) else $error("ack lost");

    property p_and;
        ##1 grpInRange == $past(gvOk && gfOk);
    endproperty
    a_and: assert property (p_and) else $error("range and");

    property p_dead;
        ##1 busDead == $past(bVLhs < deadT);
    endproperty
    a_dead: assert property (p_dead) else $error("dead bus");

    property p_ptrange;
        ptPri_q >= PRI_W'(PTPRI_MIN) && ptPri_q <= PRI_W'(PTPRI_MAX);
    endproperty
    a_ptrange: assert property (p_ptrange) else $error("pt");

    c_new: cover property (anyNew ##1 new_alarm_output);
    c_ack: cover property (warning_alarm_output ##[1:20]
                           !warning_alarm_output);
    c_range: cover property (!grpInRange ##1 grpInRange);
    c_dead: cover property (busDead);
endmodule

`default_nettype wire

//--- verilog/almon_pkg.sv
// Constants for the alarm and range monitor
package almon_pkg;
    // =========================================
    // Timing
    localparam int CLK_HZ = 125_000_000;
    localparam int NEW_PULSE_S = 1;
    localparam int NEW_PULSE_CYC = NEW_PULSE_S * CLK_HZ;
    // =========================================
    // Widths
    localparam int PCT_W = 8;
    localparam int FPCT_W = 16;
    localparam int PRI_W = 20;
    localparam int SEC_W = 10;
    localparam int MEAS_W = 16;
    localparam int CMP_W = 48;
    localparam int IRQ_W = 4;
    // =========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VHI = 8'h04;
    localparam logic [7:0] OFS_VLO = 8'h08;
    localparam logic [7:0] OFS_FHI = 8'h0C;
    localparam logic [7:0] OFS_FLO = 8'h10;
    localparam logic [7:0] OFS_DEAD = 8'h14;
    localparam logic [7:0] OFS_PTPRI = 8'h18;
    localparam logic [7:0] OFS_PTSEC = 8'h1C;
    localparam logic [7:0] OFS_RATV = 8'h20;
    localparam logic [7:0] OFS_RATF = 8'h24;
    localparam logic [7:0] OFS_FLAGS = 8'h28;
    localparam logic [7:0] OFS_ISTAT = 8'h2C;
    localparam logic [7:0] OFS_IMASK = 8'h30;
    localparam logic [7:0] OFS_WPEND = 8'h34;
    localparam logic [7:0] OFS_CPEND = 8'h38;
    // =========================================
    // Fields
    localparam int CTRL_LN = 0;
    localparam int CTRL_ACK = 1;
    localparam int IRQ_NEW = 0;
    localparam int IRQ_ACK = 1;
    localparam int IRQ_GRP = 2;
    localparam int IRQ_BUS = 3;
    // =========================================
    // Limits, steps in 1 % (voltage) and 0.01 % (frequency)
    localparam logic [31:0] VHI_RST = 32'h6E;
    localparam logic [31:0] VHI_MIN = 32'h64;
    localparam logic [31:0] VHI_MAX = 32'h96;
    localparam logic [31:0] VLO_RST = 32'h5A;
    localparam logic [31:0] VLO_MIN = 32'h32;
    localparam logic [31:0] VLO_MAX = 32'h64;
    localparam logic [31:0] FHI_RST = 32'h2904;
    localparam logic [31:0] FHI_MIN = 32'h2710;
    localparam logic [31:0] FHI_MAX = 32'h3A98;
    localparam logic [31:0] FLO_RST = 32'h251C;
    localparam logic [31:0] FLO_MIN = 32'h1388;
    localparam logic [31:0] FLO_MAX = 32'h2710;
    localparam logic [31:0] DEAD_RST = 32'h0A;
    localparam logic [31:0] PTPRI_RST = 32'h190;
    localparam logic [31:0] PTPRI_MIN = 32'h32;
    localparam logic [31:0] PTPRI_MAX = 32'h9EB10;
    localparam logic [31:0] PTSEC_RST = 32'h190;
    localparam logic [31:0] PTSEC_MIN = 32'h32;
    localparam logic [31:0] PTSEC_MAX = 32'h2B2;
    localparam logic [31:0] RATV_RST = 32'h190;
    localparam logic [31:0] RATF_RST = 32'h1388;
    localparam int V_HYST = 1;
    localparam int F_HYST = 5;
    localparam logic [CMP_W-1:0] V_SCALE = 48'h64;
    localparam logic [CMP_W-1:0] F_SCALE = 48'h2710;
endpackage

//--- dv/almon_front_model.sv
// Front end model: measured readings and acknowledge sources
`timescale 1ns/10ps
`default_nettype none
module almon_front_model
    import almon_pkg::*;
(
    // Requested readings
    input wire logic [MEAS_W-1:0] setVolt,
    input wire logic [MEAS_W-1:0] setVoltLn,
    input wire logic [MEAS_W-1:0] setFreq,
    // Acknowledge request and source
    input wire logic ackGo,
    input wire logic [1:0] ackSel,
    // Measurements
    output wire logic [MEAS_W-1:0] grpVoltLl,
    output wire logic [MEAS_W-1:0] grpVoltLn,
    output wire logic [MEAS_W-1:0] grpFreq,
    output wire logic [MEAS_W-1:0] busVoltLl,
    output wire logic [MEAS_W-1:0] busVoltLn,
    output wire logic [MEAS_W-1:0] busFreq,
    // Acknowledge sources
    output wire logic alarm_ack_input,
    output wire logic resetButton,
    output wire logic group_supervisor_ack
);
    // =========================================
    // Readings, group and bus see the same levels
    assign grpVoltLl = setVolt;
    assign grpVoltLn = setVoltLn;
    assign grpFreq = setFreq;
    assign busVoltLl = setVolt;
    assign busVoltLn = setVoltLn;
    assign busFreq = setFreq;
    assign alarm_ack_input = ackGo && ackSel == 2'h0;
    assign resetButton = ackGo && ackSel == 2'h1;
    assign group_supervisor_ack = ackGo && ackSel == 2'h2;
endmodule
`default_nettype wire

//--- dv/alarm_and_range_monitor_bench.sv
// Self-checking bench of the alarm and range monitor
`timescale 1ns/10ps
`default_nettype none
module alarm_and_range_monitor_bench
    import almon_pkg::*;
;
    localparam int PCYC = 20;
    // =========================================
    // Stimulus, outputs and bench state
    logic clk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, ackGo = 1'b0;
    logic [7:0] paddr = 8'h00, warnCond = 8'h00, critCond = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] setVolt = 16'h190, setVoltLn = 16'h190;
    logic [15:0] setFreq = 16'h1388, gLl, gLn, gF, bLl, bLn, bF;
    logic [1:0] ackSel = 2'h0;
    logic ackIn, ackBtn, ackSup, newOut, warnOut, critOut, irq;
    logic grpIn, grpDead, busIn, busDead, err;
    logic vOk = 1'b1, fOk = 1'b1, deadExp;
    integer seed = 98265;
    int error_cnt = 0, checks_done = 0, pri = 400;
    logic [7:0] ro[6] = '{OFS_VHI, OFS_VLO, OFS_FHI, OFS_FLO, OFS_PTPRI,
        OFS_PTSEC};
    logic [31:0] rr[6] = '{VHI_RST, VLO_RST, FHI_RST, FLO_RST, PTPRI_RST,
        PTSEC_RST};
    int tv[16] = '{400, 441, 437, 436, 359, 363, 364, 400, 400, 400, 400,
        400, 400, 39, 40, 400};
    int tf[16] = '{5000, 5000, 5000, 5000, 5000, 5000, 5000, 5251, 5248,
        5247, 4749, 4752, 4753, 5000, 5000, 5000};

    almon_top #(.NW(8), .NC(8), .PULSE_CYC(PCYC)) u_dut (
        .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .warnCond(warnCond),
        .critCond(critCond), .alarm_ack_input(ackIn), .resetButton(ackBtn),
        .group_supervisor_ack(ackSup), .grpVoltLl(gLl), .grpVoltLn(gLn),
        .grpFreq(gF), .busVoltLl(bLl), .busVoltLn(bLn), .busFreq(bF),
        .new_alarm_output(newOut), .warning_alarm_output(warnOut),
        .critical_alarm_output(critOut), .grpInRange(grpIn),
        .grpDead(grpDead), .busInRange(busIn), .busDead(busDead), .irq(irq));

    almon_front_model u_front (.setVolt(setVolt), .setVoltLn(setVoltLn),
        .setFreq(setFreq), .ackGo(ackGo), .ackSel(ackSel), .grpVoltLl(gLl),
        .grpVoltLn(gLn), .grpFreq(gF), .busVoltLl(bLl), .busVoltLn(bLn),
        .busFreq(bF), .alarm_ack_input(ackIn), .resetButton(ackBtn),
        .group_supervisor_ack(ackSup));

    // =========================================
    // Clock and watchdog
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        #2000000;
        error_cnt++;
        results();
    end

    // =========================================
    // Shared tasks
    task automatic results();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got,
        input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ack(input int s);
        @(posedge clk);
        ackSel <= s[1:0];
        ackGo <= 1'b1;
        @(posedge clk);
        ackGo <= 1'b0;
    endtask
    // Expected windows with hysteresis, primary volts from the PT ratio
    function automatic void expWin(input int m, input int f);
        int p;
        p = m * pri * 100;
        if (p > RATV_RST * VHI_RST * 400 || p < RATV_RST * VLO_RST * 400)
            vOk = 1'b0;
        else if (p <= RATV_RST * (VHI_RST - V_HYST) * 400 &&
            p >= RATV_RST * (VLO_RST + V_HYST) * 400)
            vOk = 1'b1;
        if (f * 10000 > RATF_RST * FHI_RST || f * 10000 < RATF_RST * FLO_RST)
            fOk = 1'b0;
        else if (f * 10000 <= RATF_RST * (FHI_RST - F_HYST) &&
            f * 10000 >= RATF_RST * (FLO_RST + F_HYST))
            fOk = 1'b1;
        deadExp = p < RATV_RST * DEAD_RST * 400;
    endfunction
    task automatic setMeas(input int m, input int f);
        setVolt <= m[15:0];
        setVoltLn <= m[15:0];
        setFreq <= f[15:0];
        expWin(m, f);
        tick(6);
        chk("grpInRange", grpIn, vOk & fOk);
        chk("busInRange", busIn, vOk & fOk);
        chk("grpDead", grpDead, deadExp);
        chk("busDead", busDead, deadExp);
    endtask

    // =========================================
    // Main sequence
    initial begin
        int w;
        repeat (6) @(posedge clk);
        sysRst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ro[i], 32'h0);
            chk("reg", rd, rr[i]);
        end
        apb(1'b1, OFS_VHI, 32'hC8);
        apb(1'b0, OFS_VHI, 32'h0);
        chk("vhi clamp", rd, VHI_MAX);
        apb(1'b1, OFS_PTSEC, 32'h3E8);
        apb(1'b0, OFS_PTSEC, 32'h0);
        chk("ptsec clamp", rd, PTSEC_MAX);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        for (int i = 0; i < 6; i++) apb(1'b1, ro[i], rr[i]);
        // Window walk, then random in-window readings
        for (int i = 0; i < 16; i++) setMeas(tv[i], tf[i]);
        for (int i = 0; i < 4; i++)
            setMeas(365 + ($unsigned($random(seed)) % 71),
                4753 + ($unsigned($random(seed)) % 495));
        apb(1'b1, OFS_PTPRI, 32'h320);
        pri = 800;
        setMeas(200, 5000);
        setMeas(19, 5000);
        apb(1'b1, OFS_PTPRI, PTPRI_RST);
        pri = 400;
        setMeas(400, 5000);
        setVoltLn <= 16'h14;
        apb(1'b1, OFS_CTRL, 32'h1);
        tick(4);
        chk("ln dead", {31'h0, grpDead}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
        tick(4);
        chk("ll dead", {31'h0, grpDead}, 32'h0);
        // Alarms, one pass per acknowledge input
        for (int k = 0; k < 3; k++) begin
            w = $random(seed);
            warnCond <= w[7:0] | 8'h03;
            tick(3);
            chk("new", {31'h0, newOut}, 32'h1);
            tick(12);
            critCond <= 8'h01 << (w[10:8]);
            tick(10);
            chk("new retrig", {31'h0, newOut}, 32'h1);
            chk("warn", {31'h0, warnOut}, 32'h1);
            chk("crit", {31'h0, critOut}, 32'h1);
            chk("masked irq", {31'h0, irq}, 32'h0);
            ack(k);
            tick(3);
            chk("warn held", {31'h0, warnOut}, 32'h1);
            warnCond <= 8'h00;
            tick(2);
            ack(k);
            tick(4);
            chk("warn acked", {31'h0, warnOut}, 32'h0);
            chk("crit held", {31'h0, critOut}, 32'h1);
            critCond <= 8'h00;
            tick(2);
            ack(k);
            tick(4);
            chk("crit acked", {31'h0, critOut}, 32'h0);
            tick(PCYC);
            chk("new end", {31'h0, newOut}, 32'h0);
        end
        // Interrupt: unmask, raise, clear by writing one
        apb(1'b1, OFS_ISTAT, 32'hF);
        apb(1'b1, OFS_IMASK, 32'h1);
        warnCond <= 8'h01;
        tick(4);
        chk("irq", {31'h0, irq}, 32'h1);
        warnCond <= 8'h00;
        apb(1'b0, OFS_ISTAT, 32'h0);
        chk("istat", rd & 32'h1, 32'h1);
        apb(1'b1, OFS_ISTAT, 32'hF);
        tick(3);
        chk("irq clear", {31'h0, irq}, 32'h0);
        results();
    end
endmodule
`default_nettype wire
